// File: spc_map.svh
// spc_map.svh: register indices, field positions, reset values and write masks
// of the sensor power and clock configuration bank
// assumes: included by its bare name; byte address on APB is four times the index
// Behaviour
// [RULE1] clock input power bit, index 20 bit 0, resets to 0
// [RULE2] analog clocks enabled by index 32 bit 0, reset 0
// [RULE3] logic clock enabled by index 32 bit 1, reset 0
// [RULE4] index 32 bit 2 picks PLL (1) or LVDS input (0); register resets 0x0004
// [RULE5] index 32 bit 3 selects 8-bit (1) or 10-bit (0) conversion, reset 0
// [RULE6] general logic enabled only while index 34 bit 0 is 1, reset 0
// [RULE7] pixel core powered up only while index 40 bit 0 is 1, reset 0
// [RULE8] column multiplexer powered up only while index 40 bit 1 is 1
// [RULE9] column bias enabled only while index 40 bit 2 is 1, reset 0
// [RULE10] index 24 bit 0 reads current PLL lock; writes there are ignored
// [RULE11] software writes reserved fields only with defaults, ignores their readback
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH
`define SPC_IDX_CLKIN 8'h14
`define SPC_IDX_LOCK 8'h18
`define SPC_IDX_RESA 8'h1A
`define SPC_IDX_RESB 8'h1B
`define SPC_IDX_CGEN 8'h20
`define SPC_IDX_GEN 8'h22
`define SPC_IDX_PIX 8'h28
`define SPC_IDX_IRQ_STAT 8'h50
`define SPC_IDX_IRQ_EN 8'h51
`define SPC_IDX_IRQ_CLR 8'h52
`define SPC_B_CLKIN_ON 0
`define SPC_B_ANA 0
`define SPC_B_LOG 1
`define SPC_B_SEL 2
`define SPC_B_ADC 3
`define SPC_B_GEN 0
`define SPC_B_IMC 0
`define SPC_B_MUX 1
`define SPC_B_CB 2
`define SPC_B_LOCK 0
`define SPC_B_EV_GAIN 0
`define SPC_B_EV_LOSS 1
`define SPC_RST_CLKIN 16'h0000
`define SPC_RST_RESA 16'h2182
`define SPC_RST_RESB 16'h3D2D
`define SPC_RST_CGEN 16'h0004
`define SPC_RST_GEN 16'h0000
`define SPC_RST_PIX 16'h0000
`define SPC_RST_IRQ 16'h0000
`define SPC_MSK_CLKIN 16'h0701
`define SPC_MSK_RESA 16'h7FFF
`define SPC_MSK_RESB 16'hFFFF
`define SPC_MSK_CGEN 16'h7F0F
`define SPC_MSK_GEN 16'h0001
`define SPC_MSK_PIX 16'h0007
`define SPC_MSK_IRQ 16'h0003
`endif

// File: spc_pkg.sv
// spc_pkg.sv: types shared by the configuration bank modules
// assumes: spc_map.svh holds the numeric constants
`include "spc_map.svh"
package spc_pkg;
  typedef logic [15:0] spc_word_t;
  typedef logic [7:0] spc_idx_t;

  // control levels driven into the analog and clocking blocks
  typedef struct packed {
    logic clk_in_on;
    logic analog_clk_en;
    logic logic_clk_en;
    logic select_pll;
    logic adc_8bit;
    logic logic_en;
    logic imc_on;
    logic mux_on;
    logic colbias_en;
  } spc_ctrl_s;

  // one register access decoded from the bus
  typedef struct packed {
    logic wr;
    logic rd;
    spc_idx_t idx;
    spc_word_t wdata;
  } spc_acc_s;
endpackage

// File: spc_apb_slave.sv
// spc_apb_slave.sv: APB decode for the configuration bank, zero wait states
// assumes: word-aligned 32-bit accesses; upper 16 data bits are ignored
`include "spc_map.svh"
module spc_apb_slave import spc_pkg::*; #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_i,             // bus clock
  input wire logic rst_n_i,           // synchronous reset, active low
  input wire logic psel_i,            // slave select
  input wire logic penable_i,         // access phase
  input wire logic pwrite_i,          // write direction
  input wire logic [ADDR_W-1:0] paddr_i, // byte address
  input wire logic [31:0] pwdata_i,   // write data
  output spc_acc_s acc_o,             // decoded access
  output logic pready_o,              // access complete
  output logic pslverr_o              // unmapped or misaligned
);
  logic hit_r;
  logic hit_nxt;
  logic setup;

  // the high-address check needs at least one bit above the index field
  if (ADDR_W < 11) begin : g_bad_addr
    $error("ADDR_W must be at least 11");
  end

  function automatic logic is_mapped(input spc_idx_t idx);
    unique case (idx)
      `SPC_IDX_CLKIN, `SPC_IDX_LOCK, `SPC_IDX_RESA, `SPC_IDX_RESB,
      `SPC_IDX_CGEN, `SPC_IDX_GEN, `SPC_IDX_PIX,
      `SPC_IDX_IRQ_STAT, `SPC_IDX_IRQ_EN, `SPC_IDX_IRQ_CLR: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  assign setup = psel_i && !penable_i;

  always_comb begin
    hit_nxt = hit_r;
    if (setup) begin
      hit_nxt = is_mapped(paddr_i[9:2]) && (paddr_i[1:0] == 2'b00)
        && (paddr_i[ADDR_W-1:10] == '0);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= hit_nxt;
    end
  end

  assign pready_o = psel_i && penable_i;
  assign pslverr_o = psel_i && penable_i && !hit_r;
  assign acc_o.wr = psel_i && penable_i && pwrite_i && hit_r;
  assign acc_o.rd = setup && !pwrite_i;
  // refused addresses point at an unused index so a read returns zero
  assign acc_o.idx = hit_nxt ? paddr_i[9:2] : 8'hFF;
  assign acc_o.wdata = pwdata_i[15:0];
endmodule

// File: spc_irq.sv
// spc_irq.sv: sticky event status, enable mask and level interrupt
// assumes: events are one-cycle pulses in the bus clock domain
module spc_irq import spc_pkg::*; #(
  parameter int NEV = 2
) (
  input wire logic clk_i,            // clock
  input wire logic rst_n_i,          // synchronous reset, active low
  input wire logic [NEV-1:0] ev_i,   // event pulses
  input wire logic en_wr_i,          // enable register write
  input wire logic clr_wr_i,         // clear register write
  input wire logic [NEV-1:0] wdata_i, // write data
  output logic [NEV-1:0] status_o,   // sticky status
  output logic [NEV-1:0] enable_o,   // enable mask
  output logic irq_o                 // level interrupt
);
  logic [NEV-1:0] status_r, status_nxt;
  logic [NEV-1:0] enable_r, enable_nxt;

  if (NEV < 1) begin : g_bad_nev
    $error("NEV must be at least 1");
  end

  always_comb begin
    // a new event wins over a clear in the same cycle
    status_nxt = (status_r & ~(clr_wr_i ? wdata_i : '0)) | ev_i;
    enable_nxt = en_wr_i ? wdata_i : enable_r;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      status_r <= '0;
      enable_r <= '0;
    end else begin
      status_r <= status_nxt;
      enable_r <= enable_nxt;
    end
  end

  assign status_o = status_r;
  assign enable_o = enable_r;
  assign irq_o = |(status_r & enable_r);
endmodule

// File: spc_top.sv
// spc_top.sv: sensor power and clock configuration bank behind APB
// assumes: one 250 MHz clock, synchronous active-low reset, PLL lock input
// synchronous to that clock
//
// The APB register port was chosen for this implementation.
`include "spc_map.svh"
module spc_top import spc_pkg::*; #(
  parameter int ADDR_W = 12
) (
  input wire logic CLOCK_I,             // 250 MHz clock
  input wire logic RESET_N_I,           // synchronous reset, active low
  input wire logic PSEL_I,              // APB select
  input wire logic PENABLE_I,           // APB enable
  input wire logic PWRITE_I,            // APB write
  input wire logic [ADDR_W-1:0] PADDR_I, // APB byte address
  input wire logic [31:0] PWDATA_I,     // APB write data
  output logic [31:0] PRDATA_O,         // APB read data
  output logic PREADY_O,                // APB ready
  output logic PSLVERR_O,               // APB error
  input wire logic PLL_LOCK_I,          // PLL lock level
  output spc_ctrl_s CTRL_O,             // power and clock controls
  output logic IRQ_O                    // lock change interrupt
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (ADDR_W < 11) begin : g_bad_addr
    $error("ADDR_W must be at least 11");
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  spc_acc_s acc;

  spc_apb_slave #(
    .ADDR_W(ADDR_W)
  ) u_apb (
    .clk_i(CLOCK_I),
    .rst_n_i(RESET_N_I),
    .psel_i(PSEL_I),
    .penable_i(PENABLE_I),
    .pwrite_i(PWRITE_I),
    .paddr_i(PADDR_I),
    .pwdata_i(PWDATA_I),
    .acc_o(acc),
    .pready_o(PREADY_O),
    .pslverr_o(PSLVERR_O)
  );

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  spc_word_t clkin_r, clkin_nxt;
  spc_word_t resa_r, resa_nxt;
  spc_word_t resb_r, resb_nxt;
  spc_word_t cgen_r, cgen_nxt;
  spc_word_t gen_r, gen_nxt;
  spc_word_t pix_r, pix_nxt;

  // reserved bits outside the mask are not stored and read as zero
  function automatic spc_word_t upd(input spc_word_t old, input spc_acc_s a,
                                    input spc_idx_t idx, input spc_word_t msk);
    upd = (a.wr && a.idx == idx) ? (a.wdata & msk) : old;
  endfunction

  always_comb begin
    clkin_nxt = upd(clkin_r, acc, `SPC_IDX_CLKIN, `SPC_MSK_CLKIN); // RULE1
    resa_nxt = upd(resa_r, acc, `SPC_IDX_RESA, `SPC_MSK_RESA);
    resb_nxt = upd(resb_r, acc, `SPC_IDX_RESB, `SPC_MSK_RESB);
    cgen_nxt = upd(cgen_r, acc, `SPC_IDX_CGEN, `SPC_MSK_CGEN); // RULE2
    gen_nxt = upd(gen_r, acc, `SPC_IDX_GEN, `SPC_MSK_GEN); // RULE6
    pix_nxt = upd(pix_r, acc, `SPC_IDX_PIX, `SPC_MSK_PIX); // RULE7
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      clkin_r <= `SPC_RST_CLKIN; // RULE1
      resa_r <= `SPC_RST_RESA;
      resb_r <= `SPC_RST_RESB;
      cgen_r <= `SPC_RST_CGEN; // RULE4
      gen_r <= `SPC_RST_GEN; // RULE6
      pix_r <= `SPC_RST_PIX; // RULE9
    end else begin
      clkin_r <= clkin_nxt;
      resa_r <= resa_nxt;
      resb_r <= resb_nxt;
      cgen_r <= cgen_nxt;
      gen_r <= gen_nxt;
      pix_r <= pix_nxt;
    end
  end

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  assign CTRL_O.clk_in_on = clkin_r[`SPC_B_CLKIN_ON]; // RULE1
  assign CTRL_O.analog_clk_en = cgen_r[`SPC_B_ANA]; // RULE2
  assign CTRL_O.logic_clk_en = cgen_r[`SPC_B_LOG]; // RULE3
  assign CTRL_O.select_pll = cgen_r[`SPC_B_SEL]; // RULE4
  assign CTRL_O.adc_8bit = cgen_r[`SPC_B_ADC]; // RULE5
  assign CTRL_O.logic_en = gen_r[`SPC_B_GEN]; // RULE6
  assign CTRL_O.imc_on = pix_r[`SPC_B_IMC]; // RULE7
  assign CTRL_O.mux_on = pix_r[`SPC_B_MUX]; // RULE8
  assign CTRL_O.colbias_en = pix_r[`SPC_B_CB]; // RULE9

  // ----------------------------------------------------------------
  // lock tracking and interrupt
  // ----------------------------------------------------------------
  logic lock_r, lock_nxt;
  logic [1:0] ev;
  logic [1:0] irq_stat;
  logic [1:0] irq_en;

  always_comb begin
    lock_nxt = PLL_LOCK_I;
    ev = '0;
    ev[`SPC_B_EV_GAIN] = PLL_LOCK_I && !lock_r;
    ev[`SPC_B_EV_LOSS] = !PLL_LOCK_I && lock_r;
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      lock_r <= 1'b0;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  spc_irq #(
    .NEV(2)
  ) u_irq (
    .clk_i(CLOCK_I),
    .rst_n_i(RESET_N_I),
    .ev_i(ev),
    .en_wr_i(acc.wr && acc.idx == `SPC_IDX_IRQ_EN),
    .clr_wr_i(acc.wr && acc.idx == `SPC_IDX_IRQ_CLR),
    .wdata_i(acc.wdata[1:0]),
    .status_o(irq_stat),
    .enable_o(irq_en),
    .irq_o(IRQ_O)
  );

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  spc_word_t rd_mux;
  spc_word_t prdata_r, prdata_nxt;

  always_comb begin
    rd_mux = 16'h0000;
    unique case (acc.idx)
      `SPC_IDX_CLKIN: rd_mux = clkin_r;
      `SPC_IDX_LOCK: rd_mux[`SPC_B_LOCK] = PLL_LOCK_I; // RULE10
      `SPC_IDX_RESA: rd_mux = resa_r;
      `SPC_IDX_RESB: rd_mux = resb_r;
      `SPC_IDX_CGEN: rd_mux = cgen_r;
      `SPC_IDX_GEN: rd_mux = gen_r;
      `SPC_IDX_PIX: rd_mux = pix_r;
      `SPC_IDX_IRQ_STAT: rd_mux[1:0] = irq_stat;
      `SPC_IDX_IRQ_EN: rd_mux[1:0] = irq_en;
      default: rd_mux = 16'h0000;
    endcase
    prdata_nxt = acc.rd ? rd_mux : prdata_r;
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      prdata_r <= 16'h0000;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  assign PRDATA_O = {16'h0000, prdata_r};

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic rst_seen_r;

  always_ff @(posedge CLOCK_I) begin
    rst_seen_r <= !RESET_N_I;
  end

  property p_clkin_wr;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    (acc.wr && acc.idx == `SPC_IDX_CLKIN)
      |=> CTRL_O.clk_in_on == $past(PWDATA_I[0]);
  endproperty
  a_clkin_wr: assert property (p_clkin_wr) else $error("clock input bit not stored"); // RULE1

  property p_ana_wr;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    (acc.wr && acc.idx == `SPC_IDX_CGEN)
      |=> CTRL_O.analog_clk_en == $past(PWDATA_I[0]);
  endproperty
  a_ana_wr: assert property (p_ana_wr) else $error("analog clock enable wrong"); // RULE2

  property p_log_wr;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    (acc.wr && acc.idx == `SPC_IDX_CGEN)
      |=> CTRL_O.logic_clk_en == $past(PWDATA_I[1]);
  endproperty
  a_log_wr: assert property (p_log_wr) else $error("logic clock enable wrong"); // RULE3

  property p_sel_reset;
    @(posedge CLOCK_I)
    rst_seen_r && RESET_N_I |-> CTRL_O.select_pll && cgen_r == 16'h0004;
  endproperty
  a_sel_reset: assert property (p_sel_reset) else $error("clock generator reset wrong"); // RULE4

  property p_adc_hold;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    !(acc.wr && acc.idx == `SPC_IDX_CGEN) |=> $stable(CTRL_O.adc_8bit)
      && $stable(CTRL_O.select_pll);
  endproperty
  a_adc_hold: assert property (p_adc_hold) else $error("width or source changed alone"); // RULE5

  property p_gen_wr;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    (acc.wr && acc.idx == `SPC_IDX_GEN) ##1 !(acc.wr && acc.idx == `SPC_IDX_GEN)
      |-> CTRL_O.logic_en == $past(PWDATA_I[0]);
  endproperty
  a_gen_wr: assert property (p_gen_wr) else $error("logic enable not held"); // RULE6

  property p_imc_wr;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    (acc.wr && acc.idx == `SPC_IDX_PIX)
      |=> CTRL_O.imc_on == $past(PWDATA_I[0]);
  endproperty
  a_imc_wr: assert property (p_imc_wr) else $error("pixel core power wrong"); // RULE7

  property p_mux_wr;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    (acc.wr && acc.idx == `SPC_IDX_PIX)
      |=> CTRL_O.mux_on == $past(PWDATA_I[1]);
  endproperty
  a_mux_wr: assert property (p_mux_wr) else $error("column mux power wrong"); // RULE8

  property p_cb_reset;
    @(posedge CLOCK_I)
    rst_seen_r && RESET_N_I |-> !CTRL_O.colbias_en && !CTRL_O.imc_on
      && !CTRL_O.logic_en && !CTRL_O.clk_in_on;
  endproperty
  a_cb_reset: assert property (p_cb_reset) else $error("power controls not off at reset"); // RULE9

  property p_lock_rd;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    (acc.rd && acc.idx == `SPC_IDX_LOCK && !PSLVERR_O)
      |=> PRDATA_O == {31'h0000_0000, $past(PLL_LOCK_I)};
  endproperty
  a_lock_rd: assert property (p_lock_rd) else $error("lock readback wrong"); // RULE10

  property p_irq_level;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    (|(ev & irq_en)) ##1 $stable(irq_en) |-> IRQ_O;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("enabled event gave no interrupt");

  property p_sel_wr;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    (acc.wr && acc.idx == `SPC_IDX_CGEN)
      |=> CTRL_O.select_pll == $past(PWDATA_I[2]);
  endproperty
  a_sel_wr: assert property (p_sel_wr) else $error("clock source select wrong"); // RULE4

  property p_adc_wr;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    (acc.wr && acc.idx == `SPC_IDX_CGEN)
      |=> CTRL_O.adc_8bit == $past(PWDATA_I[3]);
  endproperty
  a_adc_wr: assert property (p_adc_wr) else $error("conversion width wrong"); // RULE5

  property p_cb_wr;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    (acc.wr && acc.idx == `SPC_IDX_PIX)
      |=> CTRL_O.colbias_en == $past(PWDATA_I[2]);
  endproperty
  a_cb_wr: assert property (p_cb_wr) else $error("column bias enable wrong"); // RULE9

  property p_clkin_hold;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    !(acc.wr && acc.idx == `SPC_IDX_CLKIN) |=> $stable(CTRL_O.clk_in_on);
  endproperty
  a_clkin_hold: assert property (p_clkin_hold) else $error("clock input bit changed alone"); // RULE1

  property p_pix_hold;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    !(acc.wr && acc.idx == `SPC_IDX_PIX) |=> $stable(CTRL_O.imc_on)
      && $stable(CTRL_O.mux_on) && $stable(CTRL_O.colbias_en);
  endproperty
  a_pix_hold: assert property (p_pix_hold) else $error("core power changed alone"); // RULE8

  c_cgen_wr: cover property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    acc.wr && acc.idx == `SPC_IDX_CGEN);
  c_lock_rd: cover property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    acc.rd && acc.idx == `SPC_IDX_LOCK ##1 PLL_LOCK_I);
  c_err: cover property (@(posedge CLOCK_I) disable iff (!RESET_N_I) PSLVERR_O);
  c_irq: cover property (@(posedge CLOCK_I) disable iff (!RESET_N_I) $rose(IRQ_O));
  c_pix_wr: cover property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    acc.wr && acc.idx == `SPC_IDX_PIX);

endmodule

// File: sensor_power_clock_config_bench.sv
// sensor_power_clock_config_bench.sv: self-checking bench for the configuration bank
// assumes: spc_pkg compiled first; zero or more wait states on APB, byte address = 4 x index
module sensor_power_clock_config_bench import spc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  localparam logic [11:0] A_CLKIN = 12'h050;
  localparam logic [11:0] A_LOCK = 12'h060;
  localparam logic [11:0] A_RESA = 12'h068;
  localparam logic [11:0] A_RESB = 12'h06C;
  localparam logic [11:0] A_CGEN = 12'h080;
  localparam logic [11:0] A_GEN = 12'h088;
  localparam logic [11:0] A_PIX = 12'h0A0;
  localparam logic [11:0] A_IST = 12'h140;
  localparam logic [11:0] A_IEN = 12'h144;
  localparam logic [11:0] A_ICLR = 12'h148;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic lock_lvl = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  spc_ctrl_s ctrl;
  logic [31:0] rd_v;
  logic er_v;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  spc_top u_dut (
    .CLOCK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .PLL_LOCK_I(lock_lvl), .CTRL_O(ctrl),
    .IRQ_O(irq)
  );
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd_v, exp);
    check({31'h0, er_v}, 32'h0000_0000);
  endtask

  // control levels settle the cycle after the access edge
  task automatic ctl(input logic [8:0] exp);
    @(negedge clk);
    check({23'h0, ctrl}, {23'h0, exp});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    ctl(9'h020);
    rd(A_CLKIN, 32'h0000_0000);
    rd(A_CGEN, 32'h0000_0004);
    rd(A_GEN, 32'h0000_0000);
    rd(A_PIX, 32'h0000_0000);
    rd(A_LOCK, 32'h0000_0000);
    rd(A_RESA, 32'h0000_2182);
    rd(A_RESB, 32'h0000_3D2D);
  endtask

  task automatic t_cgen();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, A_CGEN, 32'h1 << i);
      ctl(9'h080 >> i);
      rd(A_CGEN, 32'h1 << i);
    end
    apb(1'b1, A_CGEN, 32'hFFFF_FFFF);
    ctl(9'h0F0);
    rd(A_CGEN, 32'h0000_7F0F);
    apb(1'b1, A_CGEN, 32'h0000_0004);
    ctl(9'h020);
  endtask

  task automatic t_power();
    apb(1'b1, A_CLKIN, 32'hFFFF_FFFF);
    ctl(9'h120);
    rd(A_CLKIN, 32'h0000_0701);
    apb(1'b1, A_GEN, 32'h0000_0001);
    ctl(9'h128);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, A_PIX, 32'h1 << i);
      ctl(9'h128 | (9'h004 >> i));
      rd(A_PIX, 32'h1 << i);
    end
    apb(1'b1, A_CLKIN, 32'h0000_0000);
    apb(1'b1, A_GEN, 32'h0000_0000);
    apb(1'b1, A_PIX, 32'h0000_0000);
    ctl(9'h020);
  endtask

  task automatic t_resv();
    apb(1'b1, A_RESA, 32'h0000_2182);
    apb(1'b1, A_RESB, 32'h0000_3D2D);
    rd(A_RESA, 32'h0000_2182);
    rd(A_RESB, 32'h0000_3D2D);
  endtask

  // unmapped, misaligned and high addresses are refused without side effects
  task automatic t_err();
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    check({31'h0, er_v}, 32'h0000_0001);
    check(rd_v, 32'h0000_0000);
    apb(1'b1, 12'h082, 32'h0000_0000);
    check({31'h0, er_v}, 32'h0000_0001);
    apb(1'b1, 12'h480, 32'h0000_0000);
    check({31'h0, er_v}, 32'h0000_0001);
    apb(1'b0, 12'h082, 32'h0000_0000);
    check({31'h0, er_v}, 32'h0000_0001);
    check(rd_v, 32'h0000_0000);
    rd(A_CGEN, 32'h0000_0004);
    ctl(9'h020);
  endtask

  task automatic t_irq();
    apb(1'b1, A_ICLR, 32'h0000_0003);
    @(posedge clk);
    lock_lvl <= 1'b1;
    repeat (3) @(posedge clk);
    rd(A_IST, 32'h0000_0001);
    check({31'h0, irq}, 32'h0000_0000);
    rd(A_LOCK, 32'h0000_0001);
    apb(1'b1, A_LOCK, 32'h0000_0000);
    check({31'h0, er_v}, 32'h0000_0000);
    rd(A_LOCK, 32'h0000_0001);
    apb(1'b1, A_IEN, 32'h0000_0001);
    @(negedge clk);
    check({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, A_ICLR, 32'h0000_0001);
    @(negedge clk);
    check({31'h0, irq}, 32'h0000_0000);
    rd(A_IST, 32'h0000_0000);
    @(posedge clk);
    lock_lvl <= 1'b0;
    repeat (3) @(posedge clk);
    rd(A_IST, 32'h0000_0002);
    check({31'h0, irq}, 32'h0000_0000);
    rd(A_LOCK, 32'h0000_0000);
    apb(1'b1, A_IEN, 32'h0000_0003);
    @(negedge clk);
    check({31'h0, irq}, 32'h0000_0001);
    rd(A_IEN, 32'h0000_0003);
    apb(1'b1, A_ICLR, 32'h0000_0002);
    @(negedge clk);
    check({31'h0, irq}, 32'h0000_0000);
    // an event while already enabled raises the interrupt with no enable write; checked three clock edges after the lock change
    @(posedge clk);
    lock_lvl <= 1'b1;
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h0000_0001);
    rd(A_IST, 32'h0000_0001);
    apb(1'b1, A_ICLR, 32'h0000_0001);
    @(negedge clk);
    check({31'h0, irq}, 32'h0000_0000);
  endtask
  // ----------------------------------------
  // sequence and watchdog
  // ----------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_cgen();
    t_power();
    t_resv();
    t_err();
    t_irq();
    wrap_up();
  end
endmodule
